// ==== rtl/dos_regs.svh ====
// Offsets, field positions, codes and timing counts of the stage block
`ifndef DOS_REGS_SVH
`define DOS_REGS_SVH
// ********************************************************************
// Timing
// ********************************************************************
`define DOS_CLK_PERIOD_NS 5
`define DOS_TS_RES_NS 1000000
`define DOS_SAMPLE_MS 5
`define DOS_PREFAULT_MS 20
`define DOS_ANGMEM_MS 100
`define DOS_MEMUSE_MS 500
`define DOS_PREFAULT_SMP (`DOS_PREFAULT_MS / `DOS_SAMPLE_MS)
`define DOS_ANGMEM_SMP (`DOS_ANGMEM_MS / `DOS_SAMPLE_MS)
`define DOS_MEMUSE_SMP (`DOS_MEMUSE_MS / `DOS_SAMPLE_MS)
`define DOS_RESET_PCT 97
`define DOS_SECT_HYST 14'sd20
`define DOS_LOWV_DEF 16'h0064
// ********************************************************************
// Register map
// ********************************************************************
`define DOS_A_GLOBAL 10'h000
`define DOS_A_TIME 10'h004
`define DOS_STAGE_SPAN 10'h080
`define DOS_S_STATIC 5'h00
`define DOS_S_CLEAR 5'h01
`define DOS_S_CNT_START 5'h02
`define DOS_S_CNT_TRIP 5'h03
`define DOS_S_CNT_BLK 5'h04
`define DOS_S_STATUS 5'h05
`define DOS_S_PREFAULT 5'h06
`define DOS_S_GROUP0 5'h10
// ********************************************************************
// Field positions and codes
// ********************************************************************
`define DOS_F_ALLOWMODE 0
`define DOS_F_FORCEEN 1
`define DOS_F_BEH_LSB 0
`define DOS_F_FORCE_LSB 4
`define DOS_F_MAG_LSB 8
`define DOS_STATIC_RST 32'h0000_0101
`define DOS_BEH_ON 3'h1
`define DOS_BEH_BLOCKED 3'h2
`define DOS_BEH_TEST 3'h3
`define DOS_BEH_TESTBLK 3'h4
`define DOS_BEH_OFF 3'h5
`define DOS_FORCE_NORMAL 2'h0
`define DOS_FORCE_START 2'h1
`define DOS_FORCE_TRIP 2'h2
`define DOS_FORCE_BLK 2'h3
`define DOS_MAG_RMS 2'h1
`define DOS_MAG_TRMS 2'h2
`define DOS_MAG_PP 2'h3
`define DOS_DLY_INSTANT 2'h0
`define DOS_DLY_DT 2'h1
`define DOS_DLY_IDMT 2'h2
`endif

// ==== rtl/dos_pkg.sv ====
// Types shared by the stage block and its users
package dos_pkg;
	typedef struct packed {
		logic [2:0][15:0] rms;
		logic [2:0][15:0] trms;
		logic [2:0][15:0] pp;
		logic signed [11:0] angleI1;
		logic signed [11:0] angleU1;
		logic signed [11:0] angleLl;
		logic [15:0] voltMag;
		logic u1Avail;
	} dos_meas_t;
	typedef struct packed {
		logic [31:0] timeMs;
		logic [3:0][5:0] pulse;
	} dos_event_t;
	typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_TRIPPED} dos_state_t;
endpackage : dos_pkg

// ==== rtl/dos_stage_top.sv ====
// Four directional overcurrent stages with events, counters and registers
`timescale 1ns/100ps
`include "dos_regs.svh"
// What this block does
// - Start, trip, blocked outputs, each with time-stamped ON and OFF events.
// - Instant mode issues start and trip events together, same time stamp.
// - Time stamps count in one millisecond steps.
// - Separate start, trip, blocked counters, each clearable by request.
// - Four independent stage instances.
// - Eight setting groups per stage, chosen by one common selector.
// - Blocking and group selection change behaviour while running.
// - Instant, definite time or inverse time with custom parameter.
// - Order: select, saturation, angle, threshold, block, delay, output.
// - Saturation check keeps magnitude valid while the transformer saturates.
// - Magnitude code 1 RMS, 2 TRMS, 3 peak-to-peak; default 1.
// - TRMS from 32 harmonics, peak-to-peak from raw samples.
// - Direction from I1 against U1, else faulty line-to-line voltage.
// - Under 1 V in a fault use remembered angle 0.5 s, then 0.
// - Pre-fault value is 20 ms average ending 20 ms before event.
// - Behaviour codes 1 on to 5 off, default 1, only if allowed.
// - Force codes 0 normal to 3 blocked, default 0, only if enabled.
// - Behaviour, force and magnitude settings live outside setting groups.
// - Pick-up above threshold, release below 97 % of threshold.
// - Directional trips need the sector; non-directional needs magnitude only.
// - Start may assert while blocking is active.
// - Remembered angle is the voltage angle 100 ms before the fault.
module dos_stage_top #(
	parameter int STAGES = 4,
	parameter int GROUPS = 8,
	parameter int MS_CYCLES = `DOS_TS_RES_NS / `DOS_CLK_PERIOD_NS
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [9:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	input wire logic measValid,
	input wire dos_pkg::dos_meas_t meas,
	input wire logic [2:0] groupSel,
	input wire logic [STAGES-1:0] blockIn,
	output logic [STAGES-1:0] startOut,
	output logic [STAGES-1:0] tripOut,
	output logic [STAGES-1:0] blockedOut,
	output dos_pkg::dos_event_t events
);
	import dos_pkg::*;

	// ****************************************************************
	// Parameter checks
	// ****************************************************************
	if (STAGES != 4 || GROUPS != 8 || MS_CYCLES < 1)
	begin : gBadParam
		$error("dos_stage_top: unsupported parameter values");
	end

	function automatic logic signed [13:0] wrapAng(
		input logic signed [13:0] a);
		logic signed [13:0] r;
		r = a;
		if (r > 14'sd1800)
			r = r - 14'sd3600;
		else if (r < -14'sd1800)
			r = r + 14'sd3600;
		return r;
	endfunction : wrapAng

	function automatic logic [15:0] satFix(
		input logic [15:0] m,
		input logic [15:0] p);
		logic [15:0] est;
		est = (p >> 2) + (p >> 3) - (p >> 6);
		return (est > m) ? est : m;
	endfunction : satFix

	// ****************************************************************
	// Millisecond time base
	// ****************************************************************
	logic [31:0] msCycle_r;
	logic [31:0] timeMs_r;
	logic msTick;
	assign msTick = (msCycle_r == 32'(MS_CYCLES - 1));

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			msCycle_r <= 32'h0;
			timeMs_r <= 32'h0;
		end
		else if (msTick)
		begin
			msCycle_r <= 32'h0;
			timeMs_r <= timeMs_r + 32'h1;
		end
		else
			msCycle_r <= msCycle_r + 32'h1;
	end

	// ****************************************************************
	// Global control and bus decode
	// ****************************************************************
	logic [1:0] global_r;
	logic [2:0] regStage;
	logic [4:0] regWord;
	logic stageHit;
	assign regStage = regAddr[9:7] - 3'h1;
	assign regWord = regAddr[6:2];
	assign stageHit = (regAddr[9:7] != 3'h0) && (regStage < 3'(STAGES));

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			global_r <= 2'h0;
		else if (regWrStb && regAddr == `DOS_A_GLOBAL)
			global_r <= regWrData[1:0];
	end

	// ****************************************************************
	// Angle reference and voltage memory
	// ****************************************************************
	logic signed [11:0] angHist_r [`DOS_ANGMEM_SMP];
	logic signed [11:0] memAng_r;
	logic [7:0] memCnt_r;
	logic lowV_r;
	logic faultAny;
	logic lowV;
	logic signed [11:0] refAng;
	logic [STAGES-1:0] pickup_r;
	assign faultAny = |pickup_r;
	assign lowV = meas.voltMag < `DOS_LOWV_DEF;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < `DOS_ANGMEM_SMP; i++)
				angHist_r[i] <= 12'sh0;
		end
		else if (measValid)
		begin
			angHist_r[0] <= meas.u1Avail ? meas.angleU1 : meas.angleLl;
			for (int i = 1; i < `DOS_ANGMEM_SMP; i++)
				angHist_r[i] <= angHist_r[i-1];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			memAng_r <= 12'sh0;
			memCnt_r <= 8'h0;
			lowV_r <= 1'b0;
		end
		else if (measValid)
		begin
			lowV_r <= lowV && faultAny;
			if (lowV && faultAny && !lowV_r)
			begin
				memAng_r <= angHist_r[`DOS_ANGMEM_SMP-1];
				memCnt_r <= 8'h0;
			end
			else if (lowV && faultAny && memCnt_r < 8'(`DOS_MEMUSE_SMP))
				memCnt_r <= memCnt_r + 8'h1;
		end
	end

	always_comb
	begin
		if (!(lowV && faultAny))
			refAng = meas.u1Avail ? meas.angleU1 : meas.angleLl;
		else if (!lowV_r || memCnt_r < 8'(`DOS_MEMUSE_SMP))
			refAng = lowV_r ? memAng_r : angHist_r[`DOS_ANGMEM_SMP-1];
		else
			refAng = 12'sh0;
	end

	// ****************************************************************
	// Stage instances
	// ****************************************************************
	logic [STAGES-1:0][31:0] stageRd;
	logic [STAGES-1:0][5:0] pulse;

	for (genvar s = 0; s < STAGES; s++)
	begin : gStage
		logic [31:0] static_r;
		logic [31:0] grpMem_r [2*GROUPS];
		logic [31:0] grpA;
		logic [31:0] grpB;
		logic [2:0] beh;
		logic [1:0] forceSel;
		logic [1:0] magSel;
		logic [15:0] mag;
		logic [15:0] thr;
		logic [15:0] dly;
		logic [1:0] dlyType;
		logic signed [13:0] diff;
		logic signed [13:0] absDiff;
		logic dirOk;
		logic above;
		logic below;
		logic pick;
		logic blk;
		logic delayDone;
		logic strt;
		logic trp;
		logic blkd;
		dos_state_t state_r;
		logic [31:0] dlyCnt_r;
		logic [39:0] acc_r;
		logic inSector_r;
		logic [15:0] hist_r [2*`DOS_PREFAULT_SMP];
		logic [15:0] prefault_r;
		logic [17:0] preSum;
		logic [2:0] out_r;
		logic [2:0] outNxt;
		logic [2:0][15:0] cnt_r;
		logic wrHere;

		assign wrHere = regWrStb && stageHit && regStage == 3'(s);

		// Static settings, kept apart from groups
		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
				static_r <= `DOS_STATIC_RST;
			else if (wrHere && regWord == `DOS_S_STATIC)
				static_r <= regWrData;
		end

		// Setting groups
		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
			begin
				for (int g = 0; g < 2*GROUPS; g++)
					grpMem_r[g] <= 32'h0;
			end
			else if (wrHere && regWord >= `DOS_S_GROUP0)
				grpMem_r[4'(regWord - `DOS_S_GROUP0)] <= regWrData;
		end

		assign grpA = grpMem_r[{groupSel, 1'b0}];
		assign grpB = grpMem_r[{groupSel, 1'b1}];
		assign thr = grpA[15:0];
		assign dly = grpA[31:16];
		assign dlyType = grpB[25:24];
		assign beh = global_r[`DOS_F_ALLOWMODE] ?
			static_r[`DOS_F_BEH_LSB +: 3] : `DOS_BEH_ON;
		assign forceSel = global_r[`DOS_F_FORCEEN] ?
			static_r[`DOS_F_FORCE_LSB +: 2] : `DOS_FORCE_NORMAL;
		assign magSel = static_r[`DOS_F_MAG_LSB +: 2];

		// Processing chain in order
		always_comb
		begin
			mag = 16'h0;
			for (int p = 0; p < 3; p++)
			begin
				logic [15:0] m;
				m = 16'h0;
				case (magSel)
					`DOS_MAG_TRMS: m = meas.trms[p];
					`DOS_MAG_PP: m = meas.pp[p];
					default: m = meas.rms[p];
				endcase
				if (magSel != `DOS_MAG_PP)
					m = satFix(m, meas.pp[p]);
				if (m > mag)
					mag = m;
			end
		end

		assign diff = wrapAng(wrapAng(14'(meas.angleI1) - 14'(refAng))
			- 14'(signed'(grpB[11:0])));
		assign absDiff = diff < 0 ? -diff : diff;
		assign dirOk = !grpB[26] || absDiff <= (14'(grpB[23:12])
			+ (inSector_r ? `DOS_SECT_HYST : 14'sh0));
		assign above = mag > thr;
		assign below = 32'(mag) * 32'd100 <
			32'(thr) * 32'(`DOS_RESET_PCT);
		assign pick = pickup_r[s] ? !below : above;
		assign blk = blockIn[s] || beh == `DOS_BEH_BLOCKED
			|| beh == `DOS_BEH_TESTBLK;
		assign delayDone = dlyType == `DOS_DLY_INSTANT
			|| (dlyType == `DOS_DLY_DT && dlyCnt_r >= 32'(dly))
			|| (dlyType == `DOS_DLY_IDMT
			&& acc_r * 40'd5 >= 40'(dly) * 40'(thr));

		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
			begin
				pickup_r[s] <= 1'b0;
				inSector_r <= 1'b0;
			end
			else if (measValid)
			begin
				pickup_r[s] <= pick && beh != `DOS_BEH_OFF;
				inSector_r <= dirOk;
			end
		end

		// Delay timing
		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
			begin
				state_r <= ST_IDLE;
				dlyCnt_r <= 32'h0;
				acc_r <= 40'h0;
			end
			else
			begin
				case (state_r)
					ST_IDLE:
					begin
						dlyCnt_r <= 32'h0;
						acc_r <= 40'h0;
						if (pickup_r[s] && dirOk && !blk)
							state_r <= ST_TIMING;
					end
					ST_TIMING:
					begin
						if (!pickup_r[s] || blk)
							state_r <= ST_IDLE;
						else if (dirOk && delayDone)
							state_r <= ST_TRIPPED;
						if (msTick)
							dlyCnt_r <= dlyCnt_r + 32'h1;
						if (measValid && !acc_r[39])
							acc_r <= acc_r + 40'(mag);
					end
					ST_TRIPPED:
						if (!pickup_r[s] || blk)
							state_r <= ST_IDLE;
					default:
						state_r <= ST_IDLE;
				endcase
			end
		end

		// Output processing
		assign strt = pickup_r[s] && dirOk;
		assign trp = strt && !blk && (state_r == ST_TRIPPED
			|| (state_r == ST_TIMING && dirOk && delayDone)
			|| (dlyType == `DOS_DLY_INSTANT && state_r != ST_TIMING));
		assign blkd = pickup_r[s] && blk;

		always_comb
		begin
			outNxt = {blkd, trp, strt};
			if (beh == `DOS_BEH_OFF)
				outNxt = 3'h0;
			case (forceSel)
				`DOS_FORCE_START: outNxt = 3'b001;
				`DOS_FORCE_TRIP: outNxt = 3'b011;
				`DOS_FORCE_BLK: outNxt = 3'b100;
				default: outNxt = outNxt;
			endcase
		end

		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
				out_r <= 3'h0;
			else
				out_r <= outNxt;
		end

		for (genvar k = 0; k < 3; k++)
		begin : gEvt
			assign pulse[s][2*k] = outNxt[k] && !out_r[k];
			assign pulse[s][2*k+1] = !outNxt[k] && out_r[k];

			always_ff @(posedge clk_sys or negedge resetn)
			begin
				if (!resetn)
					cnt_r[k] <= 16'h0;
				else if (wrHere && regWord == `DOS_S_CLEAR
					&& regWrData[k])
					cnt_r[k] <= {15'h0, pulse[s][2*k]};
				else if (pulse[s][2*k] && cnt_r[k] != 16'hffff)
					cnt_r[k] <= cnt_r[k] + 16'h1;
			end
		end

		// Pre-fault history
		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
			begin
				for (int i = 0; i < 2*`DOS_PREFAULT_SMP; i++)
					hist_r[i] <= 16'h0;
			end
			else if (measValid)
			begin
				hist_r[0] <= mag;
				for (int i = 1; i < 2*`DOS_PREFAULT_SMP; i++)
					hist_r[i] <= hist_r[i-1];
			end
		end

		always_comb
		begin
			preSum = 18'h0;
			for (int i = `DOS_PREFAULT_SMP; i < 2*`DOS_PREFAULT_SMP; i++)
				preSum = preSum + 18'(hist_r[i]);
		end

		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
				prefault_r <= 16'h0;
			else if (pulse[s][0] || pulse[s][2])
				prefault_r <= 16'(preSum / 18'(`DOS_PREFAULT_SMP));
		end

		// Read mux
		always_comb
		begin
			case (regWord)
				`DOS_S_STATIC: stageRd[s] = static_r;
				`DOS_S_CNT_START: stageRd[s] = {16'h0, cnt_r[0]};
				`DOS_S_CNT_TRIP: stageRd[s] = {16'h0, cnt_r[1]};
				`DOS_S_CNT_BLK: stageRd[s] = {16'h0, cnt_r[2]};
				`DOS_S_STATUS: stageRd[s] = {25'h0, state_r,
					dirOk, pickup_r[s], out_r};
				`DOS_S_PREFAULT: stageRd[s] = {16'h0, prefault_r};
				default:
					stageRd[s] = regWord >= `DOS_S_GROUP0 ?
						grpMem_r[4'(regWord - `DOS_S_GROUP0)] : 32'h0;
			endcase
		end

		assign startOut[s] = out_r[0];
		assign tripOut[s] = out_r[1];
		assign blockedOut[s] = out_r[2];
	end

	// ****************************************************************
	// Event port and register read
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			events <= '0;
		else
		begin
			events.pulse <= pulse;
			if (|pulse)
				events.timeMs <= timeMs_r;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			regRdData <= 32'h0;
		else if (regRdStb)
		begin
			if (regAddr == `DOS_A_GLOBAL)
				regRdData <= {30'h0, global_r};
			else if (regAddr == `DOS_A_TIME)
				regRdData <= timeMs_r;
			else if (stageHit)
				regRdData <= stageRd[regStage[1:0]];
			else
				regRdData <= 32'h0;
		end
		else
			regRdData <= 32'h0;
	end
endmodule : dos_stage_top

// ==== bench/dos_stage_checker.sv ====
// Port assertions of the stage block
`timescale 1ns/100ps
module dos_stage_checker #(
	parameter int STAGES = 4,
	parameter int GROUPS = 8,
	parameter int MS_CYCLES = 10
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [9:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [31:0] regRdData,
	input wire logic measValid,
	input wire dos_pkg::dos_meas_t meas,
	input wire logic [2:0] groupSel,
	input wire logic [STAGES-1:0] blockIn,
	input wire logic [STAGES-1:0] startOut,
	input wire logic [STAGES-1:0] tripOut,
	input wire logic [STAGES-1:0] blockedOut,
	input wire dos_pkg::dos_event_t events
);
	import dos_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	a_rdata_idle: assert property (!$past(regRdStb) |-> regRdData == '0)
		else $error("read data outside read window");
	a_time_hold: assert property (events.pulse == '0 |-> $stable(events.timeMs))
		else $error("time stamp moved without event");
	for (genvar s = 0; s < STAGES; s++)
	begin : g_st
		sequence sInstRise;
			$rose(startOut[s]) && $rose(tripOut[s]);
		endsequence
		sequence sInstEvt;
			events.pulse[s][0] && events.pulse[s][2];
		endsequence
		a_start_on: assert property ($rose(startOut[s]) |-> events.pulse[s][0])
			else $error("missing start ON event");
		a_start_off: assert property ($fell(startOut[s]) |-> events.pulse[s][1])
			else $error("missing start OFF event");
		a_trip_on: assert property ($rose(tripOut[s]) |-> events.pulse[s][2])
			else $error("missing trip ON event");
		a_trip_off: assert property ($fell(tripOut[s]) |-> events.pulse[s][3])
			else $error("missing trip OFF event");
		a_blk_on: assert property ($rose(blockedOut[s]) |-> events.pulse[s][4])
			else $error("missing blocked ON event");
		a_once_only: assert property (events.pulse[s][0] |-> $rose(startOut[s]))
			else $error("start ON event without edge");
		a_instant_pair: assert property (sInstRise |-> sInstEvt)
			else $error("instant events not together");
		a_blk_no_trip: assert property (blockedOut[s] |-> !tripOut[s])
			else $error("trip while blocked");
		a_trip_start: assert property (tripOut[s] |-> startOut[s])
			else $error("trip without start");
	end
endmodule : dos_stage_checker

// ==== bench/dos_frontend.sv ====
// Measurement front end model, one sample per period
`timescale 1ns/100ps
module dos_frontend #(
	parameter int PERIOD = 50
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0][15:0] magIn,
	output logic measValid,
	output dos_pkg::dos_meas_t meas
);
	import dos_pkg::*;
	int cnt;
	// Phase A from magIn, voltage healthy, values held between samples
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 0;
			measValid <= 1'b0;
			meas <= '0;
		end
		else
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			measValid <= (cnt == PERIOD - 1);
			if (cnt == PERIOD - 1)
			begin
				meas.rms[0] <= magIn[0];
				meas.trms[0] <= magIn[1];
				meas.pp[0] <= magIn[2];
				meas.voltMag <= 16'h2710;
				meas.u1Avail <= 1'b1;
			end
		end
	end
endmodule : dos_frontend

// ==== bench/tb_dos_stage_top.sv ====
// Self-checking testbench of the stage block
`timescale 1ns/100ps
module tb_dos_stage_top;
	import dos_pkg::*;
	localparam int MS = 10;
	localparam int PER = 5 * MS;
	localparam logic [15:0] HI = 16'h00c8;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [9:0] regAddr = '0;
	logic [31:0] regWrData = '0;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [31:0] regRdData;
	logic measValid;
	dos_meas_t meas;
	logic [2:0] groupSel = '0;
	logic [3:0] blockIn = '0;
	logic [3:0] startOut;
	logic [3:0] tripOut;
	logic [3:0] blockedOut;
	dos_event_t events;
	logic [2:0][15:0] magIn = '0;
	int fails = 0;
	int compares = 0;
	dos_stage_top #(.MS_CYCLES(MS)) i_dos_stage_top (.clk_sys(clk_sys),
		.resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.measValid(measValid), .meas(meas), .groupSel(groupSel),
		.blockIn(blockIn), .startOut(startOut), .tripOut(tripOut),
		.blockedOut(blockedOut), .events(events));
	dos_frontend #(.PERIOD(PER)) i_dos_frontend (.clk_sys(clk_sys),
		.resetn(resetn), .magIn(magIn), .measValid(measValid), .meas(meas));
	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, exp, seen);
		end
	endtask : chk
	task wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
	endtask : wr
	task rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
	endtask : rd
	task setMag(input logic [47:0] v);
		@(posedge clk_sys);
		magIn <= v;
	endtask : setMag
	task smp(input int n);
		repeat (n * PER) @(posedge clk_sys);
		#1;
	endtask : smp
	function automatic logic [9:0] stB(input int s);
		return 10'((s + 1) * 128);
	endfunction : stB
	function automatic logic getOut(input int w, input int s);
		logic [2:0][3:0] o;
		o = {blockedOut, tripOut, startOut};
		return o[w][s];
	endfunction : getOut
	task waitOut(input int w, input int s, input logic v);
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk_sys);
			#1;
			if (getOut(w, s) === v)
				return;
		end
		$display("unexpected out%0d stage%0d: expected %b, seen %b",
			w, s, v, getOut(w, s));
		fails++;
		print_verdict();
	endtask : waitOut
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task testReset();
		logic [31:0] d;
		rd(stB(0), d);
		chk("static", d, 32'h0000_0101);
		rd(stB(0) + 10'h008, d);
		chk("startCount", d, 32'h0);
		rd(10'h3fc, d);
		chk("unmapped", d, 32'h0);
		$display("test reset done");
	endtask : testReset
	task testInstant();
		logic [31:0] d;
		for (int s = 0; s < 4; s++)
			wr(stB(s) + 10'h040, 32'h0000_0064);
		setMag({32'h0, 16'h0050});
		smp(8);
		setMag({32'h0, HI});
		waitOut(0, 0, 1'b1);
		chk("startAll", {28'h0, startOut}, 32'h0000_000f);
		chk("tripAll", {28'h0, tripOut}, 32'h0000_000f);
		chk("onEvents", {8'h0, events.pulse}, 32'h0014_5145);
		rd(10'h004, d);
		chk("stampAge", {31'h0, (d - events.timeMs) < 32'd2}, 32'h1);
		setMag({32'h0, 16'h0061});
		smp(2);
		chk("holdAt97", {28'h0, startOut}, 32'h0000_000f);
		setMag({32'h0, 16'h0060});
		waitOut(0, 0, 1'b0);
		chk("offEvents", {8'h0, events.pulse}, 32'h0028_a28a);
		rd(stB(0) + 10'h008, d);
		chk("startCount", d, 32'h1);
		rd(stB(0) + 10'h00c, d);
		chk("tripCount", d, 32'h1);
		rd(stB(0) + 10'h018, d);
		chk("preFault", d, 32'h0000_0050);
		$display("test instant done");
	endtask : testInstant
	task testBlock();
		logic [31:0] d;
		blockIn <= 4'h2;
		setMag({32'h0, HI});
		waitOut(2, 1, 1'b1);
		chk("startBlocked", {31'h0, startOut[1]}, 32'h1);
		chk("tripBlocked", {31'h0, tripOut[1]}, 32'h0);
		chk("tripOther", {31'h0, tripOut[0]}, 32'h1);
		setMag(48'h0);
		waitOut(0, 1, 1'b0);
		blockIn <= 4'h0;
		rd(stB(1) + 10'h010, d);
		chk("blkCount", d, 32'h1);
		wr(stB(1) + 10'h004, 32'h0000_0007);
		rd(stB(1) + 10'h010, d);
		chk("blkCleared", d, 32'h0);
		rd(stB(1) + 10'h008, d);
		chk("startCleared", d, 32'h0);
		$display("test block done");
	endtask : testBlock
	task testMag();
		logic [47:0] m;
		for (int c = 1; c < 4; c++)
		begin
			m = 48'(HI) << (16 * (c - 1));
			wr(stB(0), 32'h0000_0001 | (32'(c) << 8));
			setMag({3{HI}} & ~m);
			smp(2);
			chk("otherMag", {31'h0, startOut[0]}, 32'h0);
			setMag(m);
			waitOut(0, 0, 1'b1);
			setMag(48'h0);
			waitOut(0, 0, 1'b0);
		end
		wr(stB(0), 32'h0000_0101);
		$display("test magnitude done");
	endtask : testMag
	task testGroup();
		logic [31:0] d;
		wr(stB(3) + 10'h078, 32'h0000_012c);
		groupSel <= 3'h7;
		setMag({32'h0, HI});
		waitOut(0, 0, 1'b1);
		smp(1);
		chk("group7", {31'h0, startOut[3]}, 32'h0);
		groupSel <= 3'h0;
		waitOut(0, 3, 1'b1);
		rd(stB(3), d);
		chk("staticKept", d, 32'h0000_0101);
		wr(stB(3) + 10'h044, 32'h0406_4384);
		waitOut(0, 3, 1'b0);
		chk("outSector", {31'h0, tripOut[3]}, 32'h0);
		wr(stB(3) + 10'h044, 32'h0406_4000);
		waitOut(0, 3, 1'b1);
		wr(stB(3) + 10'h044, 32'h0000_0000);
		setMag(48'h0);
		waitOut(0, 3, 1'b0);
		$display("test group done");
	endtask : testGroup
	task testForce();
		logic [2:0] e;
		wr(10'h000, 32'h0000_0003);
		for (int f = 1; f < 4; f++)
		begin
			e = (f == 1) ? 3'h1 : (f == 2) ? 3'h3 : 3'h4;
			wr(stB(2), 32'h0000_0101 | (32'(f) << 4));
			waitOut((f == 3) ? 2 : f - 1, 2, 1'b1);
			chk("force", {29'h0, blockedOut[2], tripOut[2], startOut[2]},
				{29'h0, e});
		end
		wr(stB(2), 32'h0000_0105);
		setMag({32'h0, HI});
		smp(2);
		chk("behOff", {31'h0, startOut[2]}, 32'h0);
		wr(stB(2), 32'h0000_0102);
		waitOut(2, 2, 1'b1);
		chk("behBlk", {31'h0, tripOut[2]}, 32'h0);
		wr(10'h000, 32'h0000_0000);
		waitOut(1, 2, 1'b1);
		setMag(48'h0);
		wr(stB(2), 32'h0000_0101);
		waitOut(0, 2, 1'b0);
		$display("test force done");
	endtask : testForce
	task testDelay();
		wr(stB(0) + 10'h040, 32'h0005_0064);
		wr(stB(0) + 10'h044, 32'h0100_0000);
		setMag({32'h0, HI});
		waitOut(0, 0, 1'b1);
		repeat (35) @(posedge clk_sys);
		#1;
		chk("dtEarly", {31'h0, tripOut[0]}, 32'h0);
		repeat (30) @(posedge clk_sys);
		#1;
		chk("dtLate", {31'h0, tripOut[0]}, 32'h1);
		setMag(48'h0);
		waitOut(0, 0, 1'b0);
		wr(stB(0) + 10'h044, 32'h0000_0000);
		$display("test delay done");
	endtask : testDelay
	initial
	begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		testReset();
		testInstant();
		testBlock();
		testMag();
		testGroup();
		testForce();
		testDelay();
		print_verdict();
	end
endmodule : tb_dos_stage_top
bind dos_stage_top dos_stage_checker #(.STAGES(STAGES), .GROUPS(GROUPS),
	.MS_CYCLES(MS_CYCLES)) i_dos_stage_checker (.clk_sys(clk_sys),
	.resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
	.measValid(measValid), .meas(meas), .groupSel(groupSel),
	.blockIn(blockIn), .startOut(startOut), .tripOut(tripOut),
	.blockedOut(blockedOut), .events(events));
